/* core/rf_event_timer.sv */
// Two event-started timers with a classic Wishbone register slave and interrupt.
// Assumes transceiver event inputs are synchronous one-cycle pulses, field inputs levels,
// and the interface tick pulses once per 13.56 MHz period of the contactless interface.
`timescale 1ns/1ps
`default_nettype none
module rf_event_timer
	import rf_event_timer_pkg::*;
#(
	parameter int N = NUM_TIMERS
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         cyc_i,
	input  wire logic         stb_i,
	input  wire logic         we_i,
	input  wire logic [7:0]   adr_i,
	input  wire logic [3:0]   sel_i,
	input  wire logic [31:0]  dat_i,
	output var  logic [31:0]  dat_o,
	output var  logic         ack_o,
	input  wire logic         contactless_interface_clock_tick_i,
	input  wire logic         rx_begin_i,
	input  wire logic         rx_four_bits_i,
	input  wire logic         rx_end_i,
	input  wire logic         tx_begin_i,
	input  wire logic         tx_end_i,
	input  wire logic         outside_field_i,
	input  wire logic         own_field_i,
	output var  logic [N-1:0] expire_o,
	output var  logic         irq_o
);

	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction : merge

	function automatic logic rate_hit(input logic [PRE_W-1:0]  pre,
	                                  input logic [RATE_W-1:0] rate);
		logic [PRE_W-1:0] mask;
		mask = PRE_W'((16'h0002 << rate) - 16'h0001);
		return (pre & mask) == mask;
	endfunction : rate_hit

	// Bus decode
	logic [IDX_W-1:0] idx;
	logic             req;
	logic             acc_wr;
	logic             acc_rd;

	assign idx    = adr_i[IDX_W+1:2];
	assign req    = cyc_i && stb_i;
	assign acc_wr = req && ack_o && we_i;
	assign acc_rd = req && ack_o && !we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req && !ack_o;
		end
	end

	// Prescaler shared by both timers
	logic [PRE_W-1:0] pre_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_r <= PRE_RESET;
		end else if (contactless_interface_clock_tick_i) begin
			pre_r <= pre_r + PRE_W'(1);
		end
	end

	// Field edge detection
	logic outside_field_r;
	logic own_field_r;
	logic outside_on;
	logic outside_off;
	logic own_on;
	logic own_off;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			outside_field_r <= 1'b0;
			own_field_r     <= 1'b0;
		end else begin
			outside_field_r <= outside_field_i;
			own_field_r     <= own_field_i;
		end
	end

	assign outside_on  = outside_field_i && !outside_field_r;
	assign outside_off = !outside_field_i && outside_field_r;
	assign own_on      = own_field_i && !own_field_r;
	assign own_off     = !own_field_i && own_field_r;

	// Per-timer registers and counters
	logic [CFG_W-1:0] cfg_r    [N];
	logic [CNT_W-1:0] preset_r [N];
	logic [CNT_W-1:0] count    [N];
	logic [N-1:0]     running;
	logic [N-1:0]     expire;
	logic [N-1:0]     go_now_r;
	logic [N-1:0]     tick;
	logic [N-1:0]     start;
	logic [N-1:0]     stop;

	genvar t;
	generate
		for (t = 0; t < N; t++) begin : g_timer
			logic [31:0] cfg_wd;
			logic [31:0] pre_wd;

			assign cfg_wd = merge({11'h000, cfg_r[t]}, dat_i, sel_i);
			assign pre_wd = merge({12'h000, preset_r[t]}, dat_i, sel_i);

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cfg_r[t]    <= CFG_RESET;
					preset_r[t] <= PRESET_RESET;
					go_now_r[t] <= 1'b0;
				end else begin
					go_now_r[t] <= 1'b0;
					if (acc_wr && idx == IDX_CFG[t]) begin
						cfg_r[t]    <= cfg_wd[CFG_W-1:0];
						go_now_r[t] <= cfg_wd[CFG_GO_NOW];
					end
					if (acc_wr && idx == IDX_PRESET[t]) begin
						preset_r[t] <= pre_wd[CNT_W-1:0];
					end
				end
			end

			assign tick[t] = contactless_interface_clock_tick_i &&
				(!cfg_r[t][CFG_SRC] ||
				 rate_hit(pre_r, cfg_r[t][CFG_RATE_LO +: RATE_W]));

			assign start[t] = go_now_r[t]
				|| (cfg_r[t][GO_RX_BEGIN] && rx_begin_i)
				|| (cfg_r[t][GO_RX_END] && rx_end_i)
				|| (cfg_r[t][GO_TX_BEGIN] && tx_begin_i)
				|| (cfg_r[t][GO_TX_END] && tx_end_i)
				|| (cfg_r[t][GO_OUT_ON] && outside_on)
				|| (cfg_r[t][GO_OUT_OFF] && outside_off)
				|| (cfg_r[t][GO_OWN_ON] && own_on)
				|| (cfg_r[t][GO_OWN_OFF] && own_off);

			// Stop wins over a start in the same cycle
			assign stop[t] = (cfg_r[t][HALT_RX_BEGIN] && rx_four_bits_i)
				|| (cfg_r[t][HALT_TX_BEGIN] && tx_begin_i)
				|| (cfg_r[t][HALT_OUT_ON] && outside_on)
				|| (cfg_r[t][HALT_OUT_OFF] && outside_off)
				|| (cfg_r[t][HALT_OWN_ON] && own_on)
				|| (cfg_r[t][HALT_OWN_OFF] && own_off);

			rf_timer_core #(
				.W (CNT_W)
			) u_core (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.on_i      (cfg_r[t][CFG_ON]),
				.reload_i  (cfg_r[t][CFG_RELOAD]),
				.preset_i  (preset_r[t]),
				.tick_i    (tick[t]),
				.start_i   (start[t]),
				.stop_i    (stop[t]),
				.count_o   (count[t]),
				.running_o (running[t]),
				.expire_o  (expire[t])
			);

			property p_fast_tick;
				@(posedge clk_i) disable iff (rst_i)
				!cfg_r[t][CFG_SRC] |-> tick[t] == contactless_interface_clock_tick_i;
			endproperty
			a_fast_tick: assert property (p_fast_tick) else $error("fast tick wrong");

			property p_half_rate;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][CFG_SRC] && cfg_r[t][CFG_RATE_LO +: RATE_W] == 3'h0)
				|-> tick[t] == (contactless_interface_clock_tick_i && pre_r[0]);
			endproperty
			a_half_rate: assert property (p_half_rate) else $error("prescale 0 wrong");

			property p_go_now;
				@(posedge clk_i) disable iff (rst_i)
				(acc_wr && idx == IDX_CFG[t] && cfg_wd[CFG_GO_NOW] && cfg_wd[CFG_ON])
				##1 !stop[t] |=> running[t];
			endproperty
			a_go_now: assert property (p_go_now) else $error("immediate start failed");

			property p_tx_halt;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][HALT_TX_BEGIN] && tx_begin_i) |=> !running[t];
			endproperty
			a_tx_halt: assert property (p_tx_halt) else $error("tx stop ignored");

			property p_rx_halt;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][HALT_RX_BEGIN] && rx_four_bits_i) |=> !running[t];
			endproperty
			a_rx_halt: assert property (p_rx_halt) else $error("rx stop ignored");

			property p_out_on_halt;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][HALT_OUT_ON] && outside_on) |=> !running[t];
			endproperty
			a_out_on_halt: assert property (p_out_on_halt) else $error("field on stop ignored");

			property p_out_off_halt;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][HALT_OUT_OFF] && outside_off) |=> !running[t];
			endproperty
			a_out_off_halt: assert property (p_out_off_halt) else $error("field off stop");

			property p_own_on_halt;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][HALT_OWN_ON] && own_on) |=> !running[t];
			endproperty
			a_own_on_halt: assert property (p_own_on_halt) else $error("own on stop ignored");

			property p_own_off_halt;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][HALT_OWN_OFF] && own_off) |=> !running[t];
			endproperty
			a_own_off_halt: assert property (p_own_off_halt) else $error("own off stop");

			property p_rx_go;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][CFG_ON] && cfg_r[t][GO_RX_BEGIN] && rx_begin_i && !stop[t])
				|=> running[t] && count[t] == $past(preset_r[t]);
			endproperty
			a_rx_go: assert property (p_rx_go) else $error("rx begin start ignored");

			property p_rx_end_go;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][CFG_ON] && cfg_r[t][GO_RX_END] && rx_end_i && !stop[t])
				|=> running[t] && count[t] == $past(preset_r[t]);
			endproperty
			a_rx_end_go: assert property (p_rx_end_go) else $error("rx end start ignored");

			property p_tx_go;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][CFG_ON] && cfg_r[t][GO_TX_BEGIN] && tx_begin_i && !stop[t])
				|=> running[t] && count[t] == $past(preset_r[t]);
			endproperty
			a_tx_go: assert property (p_tx_go) else $error("tx begin start ignored");

			property p_tx_end_go;
				@(posedge clk_i) disable iff (rst_i)
				(cfg_r[t][CFG_ON] && cfg_r[t][GO_TX_END] && tx_end_i && !stop[t])
				|=> running[t] && count[t] == $past(preset_r[t]);
			endproperty
			a_tx_end_go: assert property (p_tx_end_go) else $error("tx end start ignored");
		end
	endgenerate

	// Interrupt status, mask and expiry outputs
	logic [N-1:0] irq_stat_r;
	logic [N-1:0] irq_mask_r;
	logic [N-1:0] irq_clr;

	// Clear only what the read reported, so a late expiry is not lost
	assign irq_clr = (acc_rd && idx == IDX_IRQ_STAT) ? dat_o[N-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq_o      <= 1'b0;
			expire_o   <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | expire;
			if (acc_wr && idx == IDX_IRQ_MASK && sel_i[0]) begin
				irq_mask_r <= dat_i[N-1:0];
			end
			irq_o    <= |(irq_stat_r & irq_mask_r);
			expire_o <= expire;
		end
	end

	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> irq_o == |($past(irq_stat_r) & $past(irq_mask_r));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	property p_sticky;
		@(posedge clk_i) disable iff (rst_i)
		|expire |=> (irq_stat_r & $past(expire)) == $past(expire);
	endproperty
	a_sticky: assert property (p_sticky) else $error("expiry not latched");

	// Read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= DATA_ZERO;
		end else if (req && !ack_o) begin
			dat_o <= DATA_ZERO;
			for (int i = 0; i < N; i++) begin
				if (idx == IDX_CFG[i]) begin
					dat_o <= {11'h000, cfg_r[i]};
				end
				if (idx == IDX_PRESET[i]) begin
					dat_o <= {12'h000, preset_r[i]};
				end
				if (idx == IDX_STATUS[i]) begin
					dat_o <= {11'h000, running[i], count[i]};
				end
			end
			if (idx == IDX_IRQ_STAT) begin
				dat_o <= {30'h00000000, irq_stat_r};
			end
			if (idx == IDX_IRQ_MASK) begin
				dat_o <= {30'h00000000, irq_mask_r};
			end
		end
	end

	c_read_status: cover property (@(posedge clk_i) disable iff (rst_i)
		acc_rd && idx == IDX_STATUS[0]);

endmodule : rf_event_timer
`default_nettype wire

/* core/rf_event_timer_pkg.sv */
// Constants shared by the event timer block: register indices, config fields.
// Assumes a word-indexed Wishbone map; byte address is four times the index.
package rf_event_timer_pkg;

	localparam int NUM_TIMERS = 2;
	localparam int CNT_W      = 20;
	localparam int CFG_W      = 21;
	localparam int RATE_W     = 3;
	localparam int PRE_W      = 8;
	localparam int IDX_W      = 6;

	// Register indices
	localparam logic [IDX_W-1:0] IDX_STATUS [NUM_TIMERS] = '{6'h08, 6'h09};
	localparam logic [IDX_W-1:0] IDX_PRESET [NUM_TIMERS] = '{6'h0B, 6'h0C};
	localparam logic [IDX_W-1:0] IDX_CFG    [NUM_TIMERS] = '{6'h0E, 6'h0F};
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h18;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h19;

	// Configuration fields and the status running bit
	localparam int CFG_ON        = 0;
	localparam int CFG_RELOAD    = 1;
	localparam int CFG_SRC       = 2;
	localparam int CFG_RATE_LO   = 3;
	localparam int CFG_GO_NOW    = 6;
	localparam int GO_OWN_OFF    = 7;
	localparam int GO_OWN_ON     = 8;
	localparam int GO_OUT_OFF    = 9;
	localparam int GO_OUT_ON     = 10;
	localparam int GO_TX_END     = 11;
	localparam int GO_TX_BEGIN   = 12;
	localparam int GO_RX_END     = 13;
	localparam int GO_RX_BEGIN   = 14;
	localparam int HALT_OWN_OFF  = 15;
	localparam int HALT_OWN_ON   = 16;
	localparam int HALT_OUT_OFF  = 17;
	localparam int HALT_OUT_ON   = 18;
	localparam int HALT_TX_BEGIN = 19;
	localparam int HALT_RX_BEGIN = 20;
	localparam int STAT_RUN      = 20;

	localparam logic [CFG_W-1:0] CFG_RESET    = 21'h000000;
	localparam logic [CNT_W-1:0] PRESET_RESET = 20'h00000;
	localparam logic [PRE_W-1:0] PRE_RESET    = 8'h00;
	localparam logic [31:0]      DATA_ZERO    = 32'h00000000;

endpackage : rf_event_timer_pkg

/* core/rf_timer_core.sv */
// One 20-bit down counter with start, stop, auto-reload and expiry pulse.
// Assumes tick, start and stop are single-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
module rf_timer_core
	import rf_event_timer_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         on_i,
	input  wire logic         reload_i,
	input  wire logic [W-1:0] preset_i,
	input  wire logic         tick_i,
	input  wire logic         start_i,
	input  wire logic         stop_i,
	output var  logic [W-1:0] count_o,
	output var  logic         running_o,
	output var  logic         expire_o
);

	localparam logic [W-1:0] ONE  = W'(1);
	localparam logic [W-1:0] ZERO = W'(0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o   <= ZERO;
			running_o <= 1'b0;
			expire_o  <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (!on_i) begin
				running_o <= 1'b0;
			end else if (stop_i) begin
				running_o <= 1'b0;
			end else if (start_i) begin
				count_o   <= preset_i;
				running_o <= 1'b1;
			end else if (running_o && tick_i) begin
				if (count_o <= ONE) begin
					expire_o <= 1'b1;
					if (reload_i) begin
						count_o <= preset_i;
					end else begin
						count_o   <= ZERO;
						running_o <= 1'b0;
					end
				end else begin
					count_o <= count_o - ONE;
				end
			end
		end
	end

	property p_off_idle;
		@(posedge clk_i) disable iff (rst_i)
		!on_i |=> !running_o;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("timer runs while disabled");

	property p_start_load;
		@(posedge clk_i) disable iff (rst_i)
		(on_i && !stop_i && start_i) |=> running_o && count_o == $past(preset_i);
	endproperty
	a_start_load: assert property (p_start_load) else $error("start did not load preset");

	property p_expire_stop;
		@(posedge clk_i) disable iff (rst_i)
		(on_i && !stop_i && !start_i && running_o && tick_i && count_o == ONE && !reload_i)
		|=> expire_o && count_o == ZERO && !running_o
		##1 ($past(start_i) || (!running_o && count_o == ZERO));
	endproperty
	a_expire_stop: assert property (p_expire_stop) else $error("one-shot expiry wrong");

	property p_expire_reload;
		@(posedge clk_i) disable iff (rst_i)
		(on_i && !stop_i && !start_i && running_o && tick_i && count_o == ONE && reload_i)
		|=> expire_o && running_o && count_o == $past(preset_i);
	endproperty
	a_expire_reload: assert property (p_expire_reload) else $error("reload failed");

	property p_decrement;
		@(posedge clk_i) disable iff (rst_i)
		(on_i && !stop_i && !start_i && running_o && tick_i && count_o > ONE)
		|=> count_o == $past(count_o) - ONE && !expire_o;
	endproperty
	a_decrement: assert property (p_decrement) else $error("count did not step down");

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		(on_i && !start_i && !tick_i) |=> $stable(count_o);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without tick");

	property p_stop;
		@(posedge clk_i) disable iff (rst_i)
		(on_i && stop_i) |=> !running_o && !expire_o;
	endproperty
	a_stop: assert property (p_stop) else $error("stop event ignored");

	c_oneshot: cover property (@(posedge clk_i) disable iff (rst_i)
		start_i ##[1:40] expire_o && !running_o);
	c_reload: cover property (@(posedge clk_i) disable iff (rst_i)
		expire_o && running_o ##[1:40] expire_o);
	c_stopped: cover property (@(posedge clk_i) disable iff (rst_i)
		running_o && stop_i && on_i);

endmodule : rf_timer_core
`default_nettype wire

/* verification/rf_front_model.sv */
// Transceiver side model: interface tick, event pulses, field levels.
// Assumes the bench asks for an event by kind code and a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module rf_front_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] kind_i,
	input  wire logic       fire_i,
	input  wire logic       prep_i,
	output var  logic       tick_o,
	output var  logic [4:0] pulse_o,
	output var  logic       outside_o,
	output var  logic       own_o
);
	// Kinds 0..4 pulse; 5/6 outside on/off; 7/8 own on/off
	always_ff @(posedge clk_i) begin
		// Tick pauses for one cycle with each event, so hold without tick is seen
		tick_o <= !rst_i && !fire_i;
		pulse_o <= (fire_i && kind_i < 4'h5) ? (5'h01 << kind_i) : 5'h00;
		if (rst_i) begin
			outside_o <= 1'b0;
			own_o     <= 1'b0;
		end else if (fire_i || prep_i) begin
			// Prep puts the field at the level opposite to the event
			if (kind_i == 4'h5 || kind_i == 4'h6)
				outside_o <= (kind_i == 4'h5) ^ prep_i;
			if (kind_i == 4'h7 || kind_i == 4'h8)
				own_o <= (kind_i == 4'h7) ^ prep_i;
		end
	end
endmodule : rf_front_model
`default_nettype wire

/* verification/rf_event_timer_bench.sv */
// Self-checking bench: Wishbone register tasks and event-driven timer tests.
// Assumes the transceiver model drives all event and tick inputs.
`timescale 1ns/1ps
`default_nettype none
module rf_event_timer_bench
	import rf_event_timer_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        tick;
	logic [4:0]  pulse;
	logic        outside;
	logic        own;
	logic [1:0]  expire_o;
	logic        irq_o;
	logic [3:0]  kind = 4'h0;
	logic        fire = 1'b0;
	logic        prep = 1'b0;
	logic [31:0] q;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          n_exp = 0;
	int          n_exp1 = 0;
	int          last_t = 0;
	int          gap = 0;
	localparam logic [31:0] RUN = 32'h00100000;
	localparam int GO_BIT [8] = '{GO_RX_BEGIN, GO_RX_END, GO_TX_BEGIN, GO_TX_END,
		GO_OUT_ON, GO_OUT_OFF, GO_OWN_ON, GO_OWN_OFF};
	localparam logic [3:0] GO_KIND [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
	localparam int HALT_BIT [6] = '{HALT_RX_BEGIN, HALT_TX_BEGIN, HALT_OUT_ON,
		HALT_OUT_OFF, HALT_OWN_ON, HALT_OWN_OFF};
	localparam logic [3:0] HALT_KIND [6] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8};

	rf_event_timer rf_event_timer_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.contactless_interface_clock_tick_i(tick), .rx_begin_i(pulse[0]),
		.rx_four_bits_i(pulse[1]), .rx_end_i(pulse[2]), .tx_begin_i(pulse[3]),
		.tx_end_i(pulse[4]), .outside_field_i(outside), .own_field_i(own),
		.expire_o(expire_o), .irq_o(irq_o)
	);

	rf_front_model rf_front_model_inst (
		.clk_i(clk_i), .rst_i(rst_i), .kind_i(kind), .fire_i(fire), .prep_i(prep),
		.tick_o(tick), .pulse_o(pulse), .outside_o(outside), .own_o(own)
	);

	always #25 clk_i = !clk_i;

	task automatic results;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// Expiry pulse counter, spacing of the last two pulses, hang limit
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (expire_o[0] === 1'b1) begin
			n_exp <= n_exp + 1;
			gap <= cycles - last_t;
			last_t <= cycles;
		end
		if (expire_o[1] === 1'b1) begin
			n_exp1 <= n_exp1 + 1;
		end
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask : wb

	task automatic rdm(input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, idx, 32'h00000000);
		chk(q & m, e);
	endtask : rdm

	task automatic ev(input logic [3:0] k, input logic p);
		@(posedge clk_i);
		kind <= k;
		fire <= !p;
		prep <= p;
		@(posedge clk_i);
		fire <= 1'b0;
		prep <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : ev

	task automatic gap_chk(input logic [31:0] cfg, input logic [31:0] e);
		int n0;
		wb(1'b1, IDX_CFG[0], cfg);
		// Up to three pulses still belong to the old setting
		n0 = n_exp;
		while (n_exp < n0 + 5) @(posedge clk_i);
		chk(gap, e);
	endtask : gap_chk

	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdm(IDX_CFG[0], '1, 32'h00000000);
		rdm(IDX_STATUS[0], '1, 32'h00000000);
		rdm(IDX_PRESET[1], '1, 32'h00000000);
		rdm(6'h3F, '1, 32'h00000000);
		rdm(IDX_IRQ_MASK, '1, 32'h00000000);
		wb(1'b1, IDX_CFG[0], 32'h00000040);
		repeat (4) @(posedge clk_i);
		rdm(IDX_STATUS[0], '1, 32'h00000000);
		$display("test reset and enable done");
		wb(1'b1, IDX_PRESET[0], 32'h00000003);
		rdm(IDX_PRESET[0], '1, 32'h00000003);
		n_exp = 0;
		wb(1'b1, IDX_CFG[0], 32'h00000041);
		repeat (12) @(posedge clk_i);
		rdm(IDX_STATUS[0], '1, 32'h00000000);
		chk(n_exp, 1);
		chk(irq_o, 0);
		wb(1'b1, IDX_IRQ_MASK, 32'h00000001);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1);
		rdm(IDX_IRQ_STAT, '1, 32'h00000001);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 0);
		rdm(IDX_IRQ_STAT, '1, 32'h00000000);
		$display("test one-shot and interrupt done");
		wb(1'b1, IDX_CFG[0], 32'h00000043);
		n_exp = 0;
		repeat (40) @(posedge clk_i);
		rdm(IDX_STATUS[0], RUN, RUN);
		chk(n_exp > 5, 1);
		wb(1'b1, IDX_PRESET[0], 32'h00000001);
		gap_chk(32'h00000043, 32'h00000001);
		for (int r = 0; r < 8; r++)
			gap_chk(32'h00000047 | (r << 3), 32'h1 << (r + 1));
		wb(1'b1, IDX_CFG[0], 32'h00000000);
		$display("test reload and tick rate done");
		wb(1'b1, IDX_PRESET[1], 32'h000FFFFF);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, IDX_CFG[1], 32'h00000000);
			ev(GO_KIND[i], 1'b1);
			wb(1'b1, IDX_CFG[1], 32'h00000001 | (32'h1 << GO_BIT[i]));
			rdm(IDX_STATUS[1], RUN, 32'h00000000);
			ev(GO_KIND[i], 1'b0);
			rdm(IDX_STATUS[1], RUN, RUN);
		end
		$display("test start events done");
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, IDX_CFG[1], 32'h00000000);
			ev(HALT_KIND[i], 1'b1);
			wb(1'b1, IDX_CFG[1], 32'h00000041 | (32'h1 << HALT_BIT[i]));
			rdm(IDX_STATUS[1], RUN, RUN);
			ev(HALT_KIND[i], 1'b0);
			rdm(IDX_STATUS[1], RUN, 32'h00000000);
		end
		$display("test stop events done");
		wb(1'b1, IDX_PRESET[1], 32'h00000002);
		wb(1'b1, IDX_CFG[1], 32'h00000041);
		repeat (8) @(posedge clk_i);
		chk(n_exp1, 1);
		rdm(IDX_STATUS[1], '1, 32'h00000000);
		rdm(IDX_IRQ_STAT, 32'h00000002, 32'h00000002);
		$display("test second timer expiry done");
		results();
	end
endmodule : rf_event_timer_bench
`default_nettype wire
